// *** src/aid_diag.sv ***
// aid_diag: analog input diagnostic records, substitution and interrupts
// Functional notes
// - overflow, parameter error or missing supply report value 7fffh.
// - underflow reports value 8000h.
// - group fault indicator lights only with diagnostic interrupt enabled.
// - enabled error sends the four-byte basic record to host.
// - sixteen-byte extended record readable; first four bytes repeat basic.
// - record contents stay frozen until host finishes the handler.
// - byte 0 holds module, internal, external, channel, supply, parameter flags.
// - byte 1 reads 15h: analog class plus channel info present.
// - byte 3 bit 6 flags a lost process interrupt; rest zero.
// - byte 4 reads 71h, analog input, no further channel types.
// - byte 5 reads 08h diagnostic bits per channel.
// - byte 6 reads 08h similar channels.
// - byte 7 holds one error flag per channel.
// - bytes 8..15 give parameter error, underflow, overflow per channel.
// - no process interrupts in recording mode.
// - process interrupts only for enabled limit or end-of-cycle causes.
// - process interrupt presents the module base address.
// - diagnostic interrupt on error arrival and again on its clearing.
// - process data: overflow byte 0, underflow byte 1, cycle end byte 2 bit 3.
`default_nettype none
module aid_diag #(
  parameter int NUM_CH = aid_pkg::AID_NUM_CH
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [6:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // measurement side
  input wire logic [7:0][15:0] i_meas_value,
  input wire aid_pkg::aid_chan_stat_t [7:0] i_chan_stat,
  input wire logic i_supply_missing,
  input wire logic [7:0] i_limit_ovf,
  input wire logic [7:0] i_limit_unf,
  input wire logic i_cycle_end,
  // host side
  output logic [7:0][15:0] o_meas_value,
  output logic o_group_fault_indicator,
  output logic o_diag_irq,
  output logic [31:0] o_diag_basic,
  output logic o_proc_irq,
  output logic [15:0] o_proc_base_addr,
  output aid_pkg::aid_proc_data_t o_proc_data
);
  import aid_pkg::*;

  if (NUM_CH != 8) begin : g_bad_ch
    $error("aid_diag serves exactly eight channels");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] subst_value(input logic [15:0] raw,
                                               input aid_chan_stat_t st,
                                               input logic supply_miss);
    logic [15:0] v;
    v = raw;
    if (st.unf) begin
      v = VAL_LOW_SUB;
    end
    if (st.ovf || st.perr || supply_miss) begin
      v = VAL_HIGH_SUB;
    end
    return v;
  endfunction : subst_value

  function automatic logic [7:0] detail_byte(input aid_chan_stat_t st);
    logic [7:0] d;
    d = 8'h00;
    d[DET_PERR] = st.perr;
    d[DET_UNF] = st.unf;
    d[DET_OVF] = st.ovf;
    return d;
  endfunction : detail_byte

  // ---------------------------------------------------------------
  // supply pin synchroniser
  // ---------------------------------------------------------------
  logic supply_meta_r;
  logic supply_miss_r;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      supply_meta_r <= 1'b0;
      supply_miss_r <= 1'b0;
    end else begin
      supply_meta_r <= i_supply_missing;
      supply_miss_r <= supply_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  logic [4:0] idx;
  logic wb_req;
  logic wb_wr;
  assign idx = i_wb_adr[6:2];
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];

  logic [7:0] ctl_r;
  logic [15:0] base_r;
  logic diag_done;
  logic proc_done;
  assign diag_done = wb_wr && (idx == IDX_DIAG_DONE) && i_wb_dat[0];
  assign proc_done = wb_wr && (idx == IDX_PROC_DONE) && i_wb_dat[0];

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctl_r <= CTL_RESET;
      base_r <= BASE_ADDR_RESET;
    end else if (wb_req && i_wb_we) begin
      if (idx == IDX_CONTROL && i_wb_sel[0]) begin
        ctl_r <= i_wb_dat[7:0];
      end
      if (idx == IDX_BASE_ADDR) begin
        if (i_wb_sel[0]) begin
          base_r[7:0] <= i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
          base_r[15:8] <= i_wb_dat[15:8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // measured value substitution
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_meas_value <= '0;
    end else begin
      for (int c = 0; c < 8; c++) begin
        o_meas_value[c] <= subst_value(i_meas_value[c], i_chan_stat[c], supply_miss_r);
      end
    end
  end

  // ---------------------------------------------------------------
  // live diagnostic picture
  // ---------------------------------------------------------------
  logic lost_r;
  aid_diag_rec_t live;
  always_comb begin
    live = '0;
    for (int c = 0; c < 8; c++) begin
      live.detail[c] = detail_byte(i_chan_stat[c]);
      live.chan_err[c] = |live.detail[c];
    end
    live.summary[B0_CHANNEL] = |live.chan_err;
    live.summary[B0_SUPPLY] = supply_miss_r;
    live.summary[B0_INTERNAL] = lost_r;
    live.summary[B0_EXTERNAL] = supply_miss_r;
    for (int c = 0; c < 8; c++) begin
      live.summary[B0_PARAM] = live.summary[B0_PARAM] | i_chan_stat[c].perr;
    end
    live.summary[B0_MODULE] = |live.chan_err | supply_miss_r | lost_r;
    live.lost[B3_LOST] = lost_r;
  end

  // ---------------------------------------------------------------
  // frozen record and diagnostic interrupt
  // ---------------------------------------------------------------
  aid_diag_rec_t rec_r;
  logic diag_en;
  logic diag_evt;
  assign diag_en = ctl_r[CTL_DIAG_EN];
  // arrival and clearing both differ from the record
  assign diag_evt = diag_en && !o_diag_irq && (live != rec_r);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rec_r <= '0;
    end else if (!o_diag_irq) begin
      rec_r <= live;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_diag_irq <= 1'b0;
      o_diag_basic <= '0;
    end else if (diag_evt) begin
      o_diag_irq <= 1'b1;
      o_diag_basic <= {live.lost, 8'h00, CLASS_INFO_VAL, live.summary};
    end else if (diag_done) begin
      o_diag_irq <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_group_fault_indicator <= 1'b0;
    end else begin
      o_group_fault_indicator <= diag_en && (|rec_r.summary || |rec_r.lost);
    end
  end

  // ---------------------------------------------------------------
  // process interrupt
  // ---------------------------------------------------------------
  aid_proc_data_t proc_nxt;
  logic proc_evt;
  always_comb begin
    proc_nxt = '0;
    proc_nxt.lim_ovf = ctl_r[CTL_LIM_OVF_EN] ? i_limit_ovf : 8'h00;
    proc_nxt.lim_unf = ctl_r[CTL_LIM_UNF_EN] ? i_limit_unf : 8'h00;
    proc_nxt.eoc_byte[PD_EOC] = ctl_r[CTL_EOC_EN] && i_cycle_end;
  end
  assign proc_evt = !ctl_r[CTL_RECORD] && (proc_nxt != '0);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_proc_irq <= 1'b0;
      o_proc_data <= '0;
      o_proc_base_addr <= BASE_ADDR_RESET;
    // a cause in the done cycle reloads at once instead of vanishing
    end else if (proc_evt && (!o_proc_irq || proc_done)) begin
      o_proc_irq <= 1'b1;
      o_proc_data <= proc_nxt;
      o_proc_base_addr <= base_r;
    end else if (proc_done) begin
      o_proc_irq <= 1'b0;
    end
  end

  // lost flag: a new event while one is pending; set wins over clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lost_r <= 1'b0;
    end else if (proc_evt && o_proc_irq && !proc_done) begin
      lost_r <= 1'b1;
    end else if (diag_done) begin
      lost_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (idx)
      IDX_FAULT_SUMMARY: rd_nxt[7:0] = rec_r.summary;
      IDX_CLASS_INFO: rd_nxt[7:0] = CLASS_INFO_VAL;
      IDX_BASIC_SPARE: rd_nxt[7:0] = 8'h00;
      IDX_IRQ_LOSS: rd_nxt[7:0] = rec_r.lost;
      IDX_CHAN_TYPE: rd_nxt[7:0] = CHAN_TYPE_VAL;
      IDX_DIAG_BITS: rd_nxt[7:0] = DIAG_BITS_VAL;
      IDX_CHAN_COUNT: rd_nxt[7:0] = CHAN_COUNT_VAL;
      IDX_CHAN_ERR_VEC: rd_nxt[7:0] = rec_r.chan_err;
      IDX_CONTROL: rd_nxt[7:0] = ctl_r;
      IDX_BASE_ADDR: rd_nxt[15:0] = base_r;
      IDX_PROC_DATA: rd_nxt = o_proc_data;
      IDX_STATUS: rd_nxt[2:0] = {lost_r, o_proc_irq, o_diag_irq};
      default: begin
        if (idx >= IDX_CHAN0_DETAIL && idx <= IDX_CHAN7_DETAIL) begin
          rd_nxt[7:0] = rec_r.detail[idx[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        o_wb_dat <= rd_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_ovf_in(int c);
    i_chan_stat[c].ovf;
  endsequence
  sequence s_diag_raise;
    !o_diag_irq ##1 o_diag_irq;
  endsequence
  sequence s_proc_raise;
    !o_proc_irq ##1 o_proc_irq;
  endsequence

  AST_OVF_SUB: assert property (s_ovf_in(0) |=> o_meas_value[0] == VAL_HIGH_SUB)
    else $error("overflow value not substituted");
  AST_UNF_SUB: assert property (i_chan_stat[1].unf && !i_chan_stat[1].ovf &&
      !i_chan_stat[1].perr && !supply_miss_r |=> o_meas_value[1] == VAL_LOW_SUB)
    else $error("underflow value not substituted");
  AST_SF_GATE: assert property (!$past(diag_en) |-> !o_group_fault_indicator)
    else $error("fault indicator lit while disabled");
  AST_SF_LIT: assert property ($past(diag_en) && $past(rec_r.summary[B0_MODULE]) |->
      o_group_fault_indicator)
    else $error("fault indicator dark with error recorded");
  AST_BASIC_SENT: assert property (s_diag_raise |-> o_diag_basic[15:8] == CLASS_INFO_VAL)
    else $error("basic record not sent with interrupt");
  AST_BASIC_REC: assert property (s_diag_raise |-> o_diag_basic[7:0] == rec_r.summary &&
      o_diag_basic[31:24] == rec_r.lost)
    else $error("basic record differs from stored record");
  AST_BASIC_RSVD: assert property (o_diag_basic[23:16] == 8'h00 &&
      (o_diag_basic[31:24] & ~(8'h01 << B3_LOST)) == 8'h00)
    else $error("reserved basic record bit set");
  AST_FREEZE: assert property (o_diag_irq && $past(o_diag_irq) |-> $stable(rec_r))
    else $error("record changed during handler");
  AST_DIAG_HOLD: assert property (o_diag_irq && !diag_done |=> o_diag_irq)
    else $error("diagnostic interrupt dropped before handler end");
  AST_CHAN_ERR: assert property (!o_diag_irq |=>
      rec_r.chan_err[0] == |$past(live.detail[0]))
    else $error("channel error flag mismatch");
  AST_MOD_ERR: assert property (rec_r.chan_err != 8'h00 |->
      rec_r.summary[B0_MODULE] && rec_r.summary[B0_CHANNEL])
    else $error("summary misses a channel error");
  AST_DETAIL_RSVD: assert property (rec_r.detail[0][5:1] == 5'h00)
    else $error("reserved detail bit set");
  AST_REC_QUIET: assert property (o_proc_irq && !$past(o_proc_irq) |->
      !$past(ctl_r[CTL_RECORD]))
    else $error("process interrupt in recording mode");
  AST_EOC_OFF: assert property (proc_evt && !ctl_r[CTL_EOC_EN] &&
      (!o_proc_irq || proc_done) |=> !o_proc_data.eoc_byte[PD_EOC])
    else $error("cycle end reported while not enabled");
  AST_PROC_CAUSE: assert property (proc_evt && (!o_proc_irq || proc_done) |=>
      o_proc_irq ##0 o_proc_base_addr == $past(base_r))
    else $error("base address not presented");
  AST_EOC_BIT: assert property (s_proc_raise |->
      (o_proc_data.eoc_byte & ~(8'h01 << PD_EOC)) == 8'h00)
    else $error("reserved process data bit set");
  AST_PROC_HOLD: assert property (o_proc_irq && !proc_done |=>
      o_proc_irq && $stable(o_proc_data))
    else $error("process data changed while pending");
  AST_LOST: assert property (proc_evt && o_proc_irq && !proc_done |=> lost_r)
    else $error("lost process interrupt not flagged");
  AST_CLEAR_IRQ: assert property (diag_en && !o_diag_irq && live != rec_r |=>
      o_diag_irq)
    else $error("diagnostic change raised no interrupt");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("bus acknowledge held past one cycle");
endmodule : aid_diag
`default_nettype wire

// *** src/aid_pad.sv ***
// aid_pad: holds no logic; every design process lives in aid_diag
`default_nettype none
`default_nettype wire

// *** src/aid_pkg.sv ***
// aid_pkg: constants and carriers for the analog input diagnostic block
`default_nettype none
package aid_pkg;
  // ---------------------------------------------------------------
  // channel and record geometry
  // ---------------------------------------------------------------
  localparam int AID_NUM_CH = 8;
  localparam int AID_VAL_W = 16;
  localparam int AID_IDX_W = 5;
  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_FAULT_SUMMARY = 5'h00;
  localparam logic [4:0] IDX_CLASS_INFO = 5'h01;
  localparam logic [4:0] IDX_BASIC_SPARE = 5'h02;
  localparam logic [4:0] IDX_IRQ_LOSS = 5'h03;
  localparam logic [4:0] IDX_CHAN_TYPE = 5'h04;
  localparam logic [4:0] IDX_DIAG_BITS = 5'h05;
  localparam logic [4:0] IDX_CHAN_COUNT = 5'h06;
  localparam logic [4:0] IDX_CHAN_ERR_VEC = 5'h07;
  localparam logic [4:0] IDX_CHAN0_DETAIL = 5'h08;
  localparam logic [4:0] IDX_CHAN7_DETAIL = 5'h0f;
  localparam logic [4:0] IDX_CONTROL = 5'h10;
  localparam logic [4:0] IDX_BASE_ADDR = 5'h11;
  localparam logic [4:0] IDX_DIAG_DONE = 5'h12;
  localparam logic [4:0] IDX_PROC_DONE = 5'h13;
  localparam logic [4:0] IDX_PROC_DATA = 5'h14;
  localparam logic [4:0] IDX_STATUS = 5'h15;
  // ---------------------------------------------------------------
  // fixed record contents and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] CLASS_INFO_VAL = 8'h15;
  localparam logic [7:0] CHAN_TYPE_VAL = 8'h71;
  localparam logic [7:0] DIAG_BITS_VAL = 8'h08;
  localparam logic [7:0] CHAN_COUNT_VAL = 8'h08;
  localparam int B0_MODULE = 0;
  localparam int B0_INTERNAL = 1;
  localparam int B0_EXTERNAL = 2;
  localparam int B0_CHANNEL = 3;
  localparam int B0_SUPPLY = 4;
  localparam int B0_PARAM = 7;
  localparam int B3_LOST = 6;
  localparam int DET_PERR = 0;
  localparam int DET_UNF = 6;
  localparam int DET_OVF = 7;
  localparam int PD_EOC = 3;
  // control register bits
  localparam int CTL_DIAG_EN = 0;
  localparam int CTL_LIM_OVF_EN = 1;
  localparam int CTL_LIM_UNF_EN = 2;
  localparam int CTL_EOC_EN = 3;
  localparam int CTL_RECORD = 4;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] BASE_ADDR_RESET = 16'h0000;
  // substitute measured values
  localparam logic [15:0] VAL_HIGH_SUB = 16'h7fff;
  localparam logic [15:0] VAL_LOW_SUB = 16'h8000;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ovf;
    logic unf;
    logic perr;
  } aid_chan_stat_t;
  typedef struct packed {
    logic [7:0] spare;
    logic [7:0] eoc_byte;
    logic [7:0] lim_unf;
    logic [7:0] lim_ovf;
  } aid_proc_data_t;
  typedef struct packed {
    logic [7:0][7:0] detail;
    logic [7:0] chan_err;
    logic [7:0] lost;
    logic [7:0] summary;
  } aid_diag_rec_t;
endpackage : aid_pkg
`default_nettype wire

// *** verification/aid_diag_bench.sv ***
// aid_diag_bench: self-checking bench for the diagnostic block
`default_nettype none
module aid_diag_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import aid_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [6:0] adr = 7'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [7:0][15:0] meas = '0;
  aid_chan_stat_t [7:0] stat = '0;
  logic supply = 1'b0;
  logic eoc = 1'b0;
  logic [7:0] lovf = 8'h00;
  logic [7:0] lunf = 8'h00;
  logic [31:0] wb_dat;
  logic [31:0] basic;
  logic [31:0] last_basic;
  logic ack;
  logic gfi;
  logic dirq;
  logic pirq;
  logic [7:0][15:0] mout;
  logic [15:0] base;
  aid_proc_data_t pdata;
  int fail_count = 0;
  int n_tests = 0;
  int dcnt;
  int pcnt;
  always #2.5 i_clock = ~i_clock;
  aid_diag #(.NUM_CH(AID_NUM_CH)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
    .i_wb_dat(wdat), .o_wb_dat(wb_dat), .o_wb_ack(ack), .i_meas_value(meas),
    .i_chan_stat(stat), .i_supply_missing(supply), .i_limit_ovf(lovf),
    .i_limit_unf(lunf), .i_cycle_end(eoc), .o_meas_value(mout),
    .o_group_fault_indicator(gfi), .o_diag_irq(dirq), .o_diag_basic(basic),
    .o_proc_irq(pirq), .o_proc_base_addr(base), .o_proc_data(pdata));
  aid_host_model host (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_diag_irq(dirq),
    .i_proc_irq(pirq), .i_diag_basic(basic), .o_diag_cnt(dcnt), .o_proc_cnt(pcnt),
    .o_last_basic(last_basic));
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [4:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
  endtask : wb
  task automatic rd(input logic [4:0] idx, input logic [31:0] exp, input string nm);
    wb(1'b0, idx, 32'h0);
    chk(nm, rdat, exp);
  endtask : rd
  // waits until the chosen interrupt line is seen high
  task automatic wait_irq(input bit proc);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while ((proc ? pirq : dirq) !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      complete_run();
    end
  endtask : wait_irq
  task automatic pulse(input logic e, input logic [7:0] o, input logic [7:0] u);
    @(posedge i_clock);
    eoc <= e;
    lovf <= o;
    lunf <= u;
    @(posedge i_clock);
    eoc <= 1'b0;
    lovf <= 8'h00;
    lunf <= 8'h00;
  endtask : pulse
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs;
    logic [7:0] e [8];
    e = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h08, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(5'(i), {24'h0, e[i]}, "record");
    end
    rd(5'h0f, 32'h0, "detail7");
    rd(5'h1f, 32'h0, "unmapped");
    wb(1'b1, 5'h01, 32'h0);
    rd(5'h01, 32'h15, "class_ro");
  endtask : t_regs
  task automatic t_subst;
    meas <= {8{16'h1234}};
    stat[0].ovf <= 1'b1;
    stat[1].unf <= 1'b1;
    stat[2].perr <= 1'b1;
    repeat (4) @(posedge i_clock);
    chk("val0", 32'(mout[0]), 32'h7fff);
    chk("val1", 32'(mout[1]), 32'h8000);
    chk("val2", 32'(mout[2]), 32'h7fff);
    chk("val3", 32'(mout[3]), 32'h1234);
    chk("gfi_off", 32'(gfi), 32'h0);
    rd(5'h00, 32'h89, "summary");
    rd(5'h07, 32'h07, "chan_err");
    rd(5'h08, 32'h80, "det0");
    rd(5'h09, 32'h40, "det1");
    rd(5'h0a, 32'h01, "det2");
    stat <= '0;
    supply <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk("val_sup", 32'(mout[3]), 32'h7fff);
    rd(5'h00, 32'h15, "sum_sup");
    supply <= 1'b0;
    repeat (5) @(posedge i_clock);
    chk("no_diag", 32'(dcnt), 32'h0);
  endtask : t_subst
  task automatic t_diag;
    wb(1'b1, 5'h10, 32'h1);
    stat[0].ovf <= 1'b1;
    wait_irq(1'b0);
    chk("basic", basic, 32'h0000_1509);
    repeat (2) @(posedge i_clock);
    chk("gfi_on", 32'(gfi), 32'h1);
    stat[1].unf <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd(5'h07, 32'h01, "frozen");
    wb(1'b1, 5'h12, 32'h1);
    wait_irq(1'b0);
    rd(5'h07, 32'h03, "chan_err2");
    rd(5'h09, 32'h40, "det1b");
    stat <= '0;
    wb(1'b1, 5'h12, 32'h1);
    wait_irq(1'b0);
    chk("going", basic, 32'h0000_1500);
    // host model counts on this edge; look one edge later
    @(posedge i_clock);
    chk("dcount", 32'(dcnt), 32'h3);
    chk("host_rec", last_basic, 32'h0000_1500);
    wb(1'b1, 5'h12, 32'h1);
    repeat (4) @(posedge i_clock);
    chk("irq_idle", 32'(dirq), 32'h0);
    chk("gfi_clr", 32'(gfi), 32'h0);
    wb(1'b1, 5'h10, 32'h0);
  endtask : t_diag
  task automatic t_proc;
    wb(1'b1, 5'h11, 32'h00a5);
    wb(1'b1, 5'h10, 32'h08);
    pulse(1'b1, 8'h00, 8'h00);
    wait_irq(1'b1);
    chk("eoc", pdata, 32'h0008_0000);
    chk("base", 32'(base), 32'h00a5);
    rd(5'h14, 32'h0008_0000, "pdata_reg");
    rd(5'h15, 32'h0000_0002, "status");
    pulse(1'b1, 8'h00, 8'h00);
    repeat (2) @(posedge i_clock);
    rd(5'h03, 32'h40, "lost");
    rd(5'h00, 32'h03, "lost_sum");
    wb(1'b1, 5'h13, 32'h1);
    wb(1'b1, 5'h12, 32'h1);
    rd(5'h03, 32'h00, "lost_clr");
    wb(1'b1, 5'h10, 32'h02);
    pulse(1'b0, 8'h00, 8'h3c);
    repeat (3) @(posedge i_clock);
    chk("unf_off", 32'(pirq), 32'h0);
    pulse(1'b0, 8'h81, 8'h00);
    wait_irq(1'b1);
    chk("lim_ovf", pdata, 32'h0000_0081);
    wb(1'b1, 5'h13, 32'h1);
    wb(1'b1, 5'h10, 32'h04);
    pulse(1'b0, 8'h00, 8'h3c);
    wait_irq(1'b1);
    chk("lim_unf", pdata, 32'h0000_3c00);
    wb(1'b1, 5'h13, 32'h1);
    wb(1'b1, 5'h10, 32'h1e);
    pulse(1'b1, 8'hff, 8'hff);
    repeat (3) @(posedge i_clock);
    chk("recording", 32'(pirq), 32'h0);
    chk("pcount", 32'(pcnt), 32'h3);
  endtask : t_proc
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_regs();
    t_subst();
    t_diag();
    t_proc();
    complete_run();
  end
endmodule : aid_diag_bench
`default_nettype wire

// *** verification/aid_host_model.sv ***
// aid_host_model: host side that counts and captures interrupts
`default_nettype none
module aid_host_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // interrupt lines from the block
  input wire logic i_diag_irq,
  input wire logic i_proc_irq,
  input wire logic [31:0] i_diag_basic,
  // host view
  output var int o_diag_cnt,
  output var int o_proc_cnt,
  output var logic [31:0] o_last_basic
);
  timeunit 1ns;
  timeprecision 1ps;
  logic diag_d;
  logic proc_d;
  // --------------------------------
  // rising edges only: a held level is one request
  // --------------------------------
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      diag_d <= 1'b0;
      proc_d <= 1'b0;
      o_diag_cnt <= 0;
      o_proc_cnt <= 0;
      o_last_basic <= 32'h0;
    end else begin
      diag_d <= i_diag_irq;
      proc_d <= i_proc_irq;
      if (i_diag_irq && !diag_d) begin
        o_diag_cnt <= o_diag_cnt + 1;
        o_last_basic <= i_diag_basic;
      end
      if (i_proc_irq && !proc_d) begin
        o_proc_cnt <= o_proc_cnt + 1;
      end
    end
  end
endmodule : aid_host_model
`default_nettype wire
